// ---- verilog/psrm_top.sv ----
// Power state and reset manager with APB register access.
// Assumes asynchronous comparator pins and a calibration source on pclk.
//
// Behaviour
// - Transitions use inputs filtered within three cycles
// - Exactly four states: sleep, idle, limp, active
// - Power-up when main supply exceeds start threshold
// - Power-up enters sleep, outputs off, registers reset
// - Sleep exit waits for the start-up delay
// - Idle keeps regulators on, never switches
// - Idle with digital supply accepts register access
// - Limp entry resets registers; reads only
// - Active switches only while dimming input high
// - High-side driver needs its bootstrap comparator good
// - Any reset sets the transmission error flag
// - Enable undervoltage disables serial, resets, sleeps
// - Enable undervoltage stops regulator, switching, communication
// - Digital undervoltage blocks drivers, serial, resets registers
// - Driver supply undervoltage stops switching, keeps registers
// - Soft reset restores registers except monitor select
// - Calibration result survives soft reset, readable when enabled
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module psrm_top #(
  parameter int STARTUP_NS = 100000
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        main_supply_ok,
  input  wire logic        enable_undervoltage_input,
  input  wire logic        driver_regulator_output_ok,
  input  wire logic        external_driver_supply_ok,
  input  wire logic        digital_supply_ok,
  input  wire logic        limp_home_input,
  input  wire logic        dimming_input,
  input  wire logic [1:0]  bootstrap_ok,
  input  wire logic        cal_valid,
  input  wire logic [7:0]  cal_value,
  output logic [1:0]       power_state,
  output logic             internal_regulator_en,
  output logic             driver_regulator_en,
  output logic             switching_en,
  output logic [1:0]       high_side_gate_drivers_en,
  output logic             serial_en,
  output logic             register_reset,
  output logic             transmission_error_flag,
  output logic             irq
);

  // Least delay rounds up to whole cycles
  localparam int STARTUP_CYC = (STARTUP_NS + psrm_pkg::CLK_NS - 1) / psrm_pkg::CLK_NS;
  localparam logic [15:0] STARTUP_LAST = 16'(STARTUP_CYC - 1);

  // Per-bit glitch filter: accept a level seen on three samples
  function automatic psrm_pkg::psrm_sup_t filt3(input psrm_pkg::psrm_sup_t s,
                                                input psrm_pkg::psrm_sup_t h1,
                                                input psrm_pkg::psrm_sup_t h2,
                                                input psrm_pkg::psrm_sup_t f);
    logic [6:0] stable;
    stable = ~(s ^ h1) & ~(s ^ h2);
    return psrm_pkg::psrm_sup_t'((stable & s) | (~stable & f));
  endfunction

  // Pin synchronisers
  psrm_pkg::psrm_pin_t pin_raw;
  psrm_pkg::psrm_pin_t meta_q;
  psrm_pkg::psrm_pin_t sync_q;

  assign pin_raw = '{vin_ok:  main_supply_ok,
                     en:      enable_undervoltage_input,
                     drv_ok:  driver_regulator_output_ok,
                     ext_ok:  external_driver_supply_ok,
                     vdd_ok:  digital_supply_ok,
                     lh:      limp_home_input,
                     dim:     dimming_input,
                     boot_ok: bootstrap_ok};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
    end
  end

  // Registers
  logic [2:0]  ctrl_q;
  logic [2:0]  ctrl_d;
  logic [7:0]  mux_q;
  logic [7:0]  mux_d;
  logic [7:0]  cal_q;
  logic [3:0]  irq_en_q;
  logic [3:0]  irq_en_d;
  logic [3:0]  irq_st_q;
  logic        txerr_q;
  logic [31:0] prdata_q;

  // Filter stage
  psrm_pkg::psrm_sup_t flt_in;
  psrm_pkg::psrm_sup_t h1_q;
  psrm_pkg::psrm_sup_t h2_q;
  psrm_pkg::psrm_sup_t f_q;

  assign flt_in = '{vin: sync_q.vin_ok, en: sync_q.en, drv: sync_q.drv_ok,
                    ext: sync_q.ext_ok, vdd: sync_q.vdd_ok, lh: sync_q.lh,
                    idle: ctrl_q[psrm_pkg::CTRL_IDLE]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h1_q <= '0;
      h2_q <= '0;
      f_q  <= '0;
    end else begin
      h1_q <= flt_in;
      h2_q <= h1_q;
      f_q  <= filt3(flt_in, h1_q, h2_q, f_q);
    end
  end

  // State selection
  psrm_pkg::psrm_state_t state_q;
  psrm_pkg::psrm_state_t state_d;
  psrm_pkg::psrm_state_t target;
  logic [15:0]           wake_cnt_q;
  logic [15:0]           wake_cnt_d;
  logic                  wake_done;

  // Main supply low or enable low forces sleep; limp beats idle/active
  assign target = (!f_q.vin || !f_q.en) ? psrm_pkg::PS_SLEEP :
                  f_q.lh                ? psrm_pkg::PS_LIMP :
                  (f_q.idle || !f_q.vdd) ? psrm_pkg::PS_IDLE :
                                          psrm_pkg::PS_ACTIVE;
  assign wake_done = (wake_cnt_q == STARTUP_LAST);

  always_comb begin
    state_d    = target;
    wake_cnt_d = 16'h0000;
    case (state_q)
      psrm_pkg::PS_SLEEP: begin
        if (target != psrm_pkg::PS_SLEEP) begin
          state_d    = wake_done ? target : psrm_pkg::PS_SLEEP;
          wake_cnt_d = wake_cnt_q + 16'h0001;
        end
      end
      psrm_pkg::PS_IDLE,
      psrm_pkg::PS_LIMP,
      psrm_pkg::PS_ACTIVE: state_d = target;
      default: state_d = psrm_pkg::PS_SLEEP;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= psrm_pkg::PS_SLEEP;
      wake_cnt_q <= 16'h0000;
    end else begin
      state_q    <= state_d;
      wake_cnt_q <= wake_cnt_d;
    end
  end

  // Control outputs
  psrm_pkg::psrm_out_t out_d;
  psrm_pkg::psrm_out_t out_q;
  logic                awake;
  logic                sw_ok;

  assign awake = (state_q != psrm_pkg::PS_SLEEP);
  // Any driver-side undervoltage stops switching without touching registers
  assign sw_ok = (state_q == psrm_pkg::PS_ACTIVE) && sync_q.dim && f_q.drv &&
                 f_q.ext && f_q.vdd && f_q.en && f_q.vin;

  assign out_d.int_reg_en = awake;
  assign out_d.drv_reg_en = awake && f_q.en;
  assign out_d.switch_en  = sw_ok;
  assign out_d.hs_en      = {2{sw_ok}} & sync_q.boot_ok;
  assign out_d.serial_en  = awake && f_q.vdd && f_q.en;
  assign out_d.write_en   = out_d.serial_en &&
                            (state_q != psrm_pkg::PS_LIMP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  // Register reset sources
  logic hard_clr;
  logic soft_rst;
  logic hard_clr_q;

  // Sleep, digital undervoltage and limp entry all clear the register file
  assign hard_clr = (state_d == psrm_pkg::PS_SLEEP) || !f_q.vdd ||
                    (state_d == psrm_pkg::PS_LIMP && state_q != psrm_pkg::PS_LIMP);

  // APB decode
  logic access;
  logic setup;
  logic hit_r;
  logic hit_w;
  logic wr_ok;
  logic wr_ctrl;
  logic wr_mux;
  logic wr_iclr;
  logic wr_ien;
  logic [31:0] rdata;

  assign access  = psel && penable;
  assign setup   = psel && !penable;
  assign hit_w   = (paddr == psrm_pkg::OFS_CTRL) || (paddr == psrm_pkg::OFS_MUX) ||
                   (paddr == psrm_pkg::OFS_IRQ_CLR) || (paddr == psrm_pkg::OFS_IRQ_EN);
  assign hit_r   = (paddr == psrm_pkg::OFS_CTRL) || (paddr == psrm_pkg::OFS_MUX) ||
                   (paddr == psrm_pkg::OFS_STAT) || (paddr == psrm_pkg::OFS_CAL) ||
                   (paddr == psrm_pkg::OFS_IRQ_ST) || (paddr == psrm_pkg::OFS_IRQ_EN);
  // Writes in limp or without a live serial path are refused
  assign wr_ok   = access && pwrite && hit_w && out_d.write_en;
  assign wr_ctrl = wr_ok && (paddr == psrm_pkg::OFS_CTRL);
  assign wr_mux  = wr_ok && (paddr == psrm_pkg::OFS_MUX);
  assign wr_iclr = wr_ok && (paddr == psrm_pkg::OFS_IRQ_CLR);
  assign wr_ien  = wr_ok && (paddr == psrm_pkg::OFS_IRQ_EN);
  assign soft_rst = wr_ctrl && pwdata[psrm_pkg::CTRL_SOFT_RST];

  assign pready  = 1'b1;
  assign pslverr = access && (pwrite ? !(hit_w && out_d.write_en)
                                     : !(hit_r && out_d.serial_en));

  always_comb begin
    rdata = 32'h0000_0000;
    if (out_d.serial_en) begin
      case (paddr)
        psrm_pkg::OFS_CTRL:   rdata = {29'h0, ctrl_q[2], 1'b0, ctrl_q[0]};
        psrm_pkg::OFS_MUX:    rdata = {24'h0, mux_q};
        psrm_pkg::OFS_STAT:   rdata = {17'h0, f_q, 2'h0, out_q.write_en,
                                       out_q.serial_en, out_q.switch_en, txerr_q,
                                       2'(state_q)};
        // Result hidden unless readout is enabled
        psrm_pkg::OFS_CAL:    rdata = ctrl_q[psrm_pkg::CTRL_CAL_RD] ?
                                      {24'h0, cal_q} : 32'h0000_0000;
        psrm_pkg::OFS_IRQ_ST: rdata = {28'h0, irq_st_q};
        psrm_pkg::OFS_IRQ_EN: rdata = {28'h0, irq_en_q};
        default:              rdata = 32'h0000_0000;
      endcase
    end
  end

  // Writable register file
  always_comb begin
    ctrl_d   = ctrl_q;
    mux_d    = mux_q;
    irq_en_d = irq_en_q;
    if (wr_ctrl) begin
      ctrl_d = {pwdata[psrm_pkg::CTRL_CAL_RD], 1'b0, pwdata[psrm_pkg::CTRL_IDLE]};
    end
    if (wr_mux) begin
      mux_d = pwdata[7:0];
    end
    if (wr_ien) begin
      irq_en_d = pwdata[3:0];
    end
    if (soft_rst) begin
      ctrl_d   = psrm_pkg::CTRL_RST;
      irq_en_d = psrm_pkg::IRQ_EN_RST;
    end
    if (hard_clr) begin
      ctrl_d   = psrm_pkg::CTRL_RST;
      mux_d    = psrm_pkg::MUX_RST;
      irq_en_d = psrm_pkg::IRQ_EN_RST;
    end
  end

  // Interrupt events
  logic [3:0] ev;
  logic       drv_uv_q;
  logic       drv_uv;

  assign drv_uv = awake && (!f_q.drv || !f_q.ext);
  assign ev[psrm_pkg::IRQ_STATE] = (state_d != state_q);
  assign ev[psrm_pkg::IRQ_RESET] = (hard_clr && !hard_clr_q) || soft_rst;
  assign ev[psrm_pkg::IRQ_DRVUV] = drv_uv && !drv_uv_q;
  assign ev[psrm_pkg::IRQ_VDDUV] = awake && !f_q.vdd && hard_clr && !hard_clr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= psrm_pkg::CTRL_RST;
      mux_q      <= psrm_pkg::MUX_RST;
      irq_en_q   <= psrm_pkg::IRQ_EN_RST;
      irq_st_q   <= 4'h0;
      hard_clr_q <= 1'b1;
      drv_uv_q   <= 1'b0;
      prdata_q   <= 32'h0000_0000;
    end else begin
      ctrl_q     <= ctrl_d;
      mux_q      <= mux_d;
      irq_en_q   <= irq_en_d;
      // New events win over a clear in the same cycle
      irq_st_q   <= (irq_st_q & ~(wr_iclr ? pwdata[3:0] : 4'h0)) | ev;
      hard_clr_q <= hard_clr;
      drv_uv_q   <= drv_uv;
      prdata_q   <= setup ? rdata : prdata_q;
    end
  end

  // Calibration result: only power-on reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_q <= psrm_pkg::CAL_RST;
    end else if (cal_valid) begin
      cal_q <= cal_value;
    end
  end

  // Transmission error flag: power-on value is set; reset sources win over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txerr_q <= 1'b1;
    end else if (hard_clr || soft_rst) begin
      txerr_q <= 1'b1;
    end else if (wr_ctrl && pwdata[psrm_pkg::CTRL_TERCLR]) begin
      txerr_q <= 1'b0;
    end
  end

  assign prdata                    = prdata_q;
  assign power_state               = 2'(state_q);
  assign internal_regulator_en     = out_q.int_reg_en;
  assign driver_regulator_en       = out_q.drv_reg_en;
  assign switching_en              = out_q.switch_en;
  assign high_side_gate_drivers_en = out_q.hs_en;
  assign serial_en                 = out_q.serial_en;
  assign register_reset            = hard_clr_q;
  assign transmission_error_flag   = txerr_q;
  assign irq                       = |(irq_st_q & irq_en_q);

  // Checks
  AST_FILTER: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_q.vdd_ok == 1'b1) [*3] |=> f_q.vdd) else $error("filter too slow");
  AST_POWERUP: assert property (@(posedge pclk) disable iff (!presetn)
    !f_q.vin |=> state_q == psrm_pkg::PS_SLEEP) else $error("no sleep without supply");
  AST_SLEEP_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == psrm_pkg::PS_SLEEP |-> !out_d.switch_en && !out_d.serial_en &&
    ctrl_q == psrm_pkg::CTRL_RST && mux_q == psrm_pkg::MUX_RST)
    else $error("sleep not quiet");
  AST_STARTUP: assert property (@(posedge pclk) disable iff (!presetn)
    $past(state_q) == psrm_pkg::PS_SLEEP && state_q != psrm_pkg::PS_SLEEP
    |-> $past(wake_cnt_q) == STARTUP_LAST) else $error("start-up delay short");
  AST_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == psrm_pkg::PS_IDLE |-> !out_d.switch_en && out_d.int_reg_en)
    else $error("idle switching");
  AST_LIMP_WR: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && state_q == psrm_pkg::PS_LIMP |-> pslverr && !wr_ok)
    else $error("limp write taken");
  AST_DIM: assert property (@(posedge pclk) disable iff (!presetn)
    out_d.switch_en |-> sync_q.dim && state_q == psrm_pkg::PS_ACTIVE)
    else $error("switching without dim");
  AST_BOOT: assert property (@(posedge pclk) disable iff (!presetn)
    out_d.hs_en[1] || out_d.hs_en[0] |-> (out_d.hs_en & ~sync_q.boot_ok) == 2'b00)
    else $error("high side without bootstrap");
  AST_TXERR: assert property (@(posedge pclk) disable iff (!presetn)
    soft_rst || hard_clr |=> txerr_q) else $error("flag not set after reset");
  AST_EN_UV: assert property (@(posedge pclk) disable iff (!presetn)
    !f_q.en |=> state_q == psrm_pkg::PS_SLEEP ##1 !out_q.serial_en)
    else $error("enable low not honoured");
  AST_VDD_UV: assert property (@(posedge pclk) disable iff (!presetn)
    !f_q.vdd |=> ctrl_q == psrm_pkg::CTRL_RST && out_q.hs_en == 2'b00 && !out_q.serial_en)
    else $error("digital undervoltage ignored");
  AST_DRV_UV: assert property (@(posedge pclk) disable iff (!presetn)
    (!f_q.drv || !f_q.ext) && !hard_clr && !wr_ok |=> !out_q.switch_en && $stable(mux_q))
    else $error("driver undervoltage mishandled");
  AST_SOFT: assert property (@(posedge pclk) disable iff (!presetn)
    soft_rst && !hard_clr |=> ctrl_q == psrm_pkg::CTRL_RST && $stable(mux_q))
    else $error("soft reset wrong");
  AST_CAL: assert property (@(posedge pclk) disable iff (!presetn)
    soft_rst && !cal_valid |=> $stable(cal_q)) else $error("calibration lost");
  AST_LIMP: assert property (@(posedge pclk) disable iff (!presetn)
    f_q.lh && f_q.vin && f_q.en && awake |=> state_q == psrm_pkg::PS_LIMP)
    else $error("limp not entered");
  AST_ACTIVE: assert property (@(posedge pclk) disable iff (!presetn)
    awake && f_q.vin && f_q.en && f_q.vdd && !f_q.lh && !f_q.idle
    |=> state_q == psrm_pkg::PS_ACTIVE) else $error("active not entered");

endmodule // psrm_top
`default_nettype wire

// ---- verilog/psrm_pkg.sv ----
// Power state and reset manager: shared constants, states and carriers.
// Assumes a 50 MHz pclk and an APB slave with 8-bit byte addresses.
`default_nettype none
package psrm_pkg;

  localparam int CLK_NS = 20;

  // Power states
  typedef enum logic [1:0] {PS_SLEEP, PS_IDLE, PS_LIMP, PS_ACTIVE} psrm_state_t;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_MUX     = 8'h04;
  localparam logic [7:0] OFS_STAT    = 8'h08;
  localparam logic [7:0] OFS_CAL     = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h18;

  // device_control_register fields
  localparam int CTRL_IDLE  = 0;
  localparam int CTRL_SOFT_RST = 1;
  localparam int CTRL_CAL_RD   = 2;
  localparam int CTRL_TERCLR = 3;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] MUX_RST  = 8'h00;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;
  localparam logic [7:0] CAL_RST  = 8'h00;

  // Status register fields
  localparam int STAT_STATE = 0;
  localparam int STAT_TXERR = 2;
  localparam int STAT_SW    = 3;
  localparam int STAT_SER   = 4;
  localparam int STAT_WR    = 5;
  localparam int STAT_FLT   = 8;

  // Interrupt status bits
  localparam int IRQ_STATE = 0;
  localparam int IRQ_RESET = 1;
  localparam int IRQ_DRVUV = 2;
  localparam int IRQ_VDDUV = 3;

  // Synchronised pins
  typedef struct packed {
    logic       vin_ok;
    logic       en;
    logic       drv_ok;
    logic       ext_ok;
    logic       vdd_ok;
    logic       lh;
    logic       dim;
    logic [1:0] boot_ok;
  } psrm_pin_t;

  // Filtered transition inputs
  typedef struct packed {
    logic vin;
    logic en;
    logic drv;
    logic ext;
    logic vdd;
    logic lh;
    logic idle;
  } psrm_sup_t;

  // Control outputs
  typedef struct packed {
    logic       int_reg_en;
    logic       drv_reg_en;
    logic       switch_en;
    logic [1:0] hs_en;
    logic       serial_en;
    logic       write_en;
  } psrm_out_t;

endpackage
`default_nettype wire

// ---- test/psrm_partner.sv ----
// Partner model: supply comparators and host control pins.
// Assumes the bench sets wanted levels; pins follow one pclk edge later.
`timescale 1ns/1ps
`default_nettype none
module psrm_partner (
  input  wire psrm_pkg::psrm_pin_t want,
  input  wire logic                pclk,
  output var  psrm_pkg::psrm_pin_t pins
);
  // All comparators read low before power is applied
  initial pins = '0;
  // Launched on the edge so a pin never moves in a sampling step
  always @(posedge pclk) begin
    pins <= want;
  end
endmodule // psrm_partner
`default_nettype wire

// ---- test/tb_power_state_reset_manager.sv ----
// Bench: drives supplies, host pins and APB; judges states and outputs.
// Assumes a 20 ns pclk and a start-up delay cut to 200 ns (10 cycles).
`timescale 1ns/1ps
`default_nettype none
module tb_power_state_reset_manager;
  localparam int SU = 10;
  localparam psrm_pkg::psrm_pin_t GOOD = 9'h1F5;
  logic                pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic                pwrite = 1'b0, cal_valid = 1'b0;
  logic [7:0]          paddr = 8'h00, cal_value = 8'h00;
  logic [31:0]         pwdata = 32'h0, prdata;
  logic [1:0]          power_state, hs;
  logic                int_en, drv_en, sw, ser, pready, pslverr, irq, rr, txerr;
  logic [5:0]          outs;
  psrm_pkg::psrm_pin_t want = '0, pins;
  int                  n_fail = 0, comparisons = 0, cyc = 0;

  assign outs = {int_en, drv_en, sw, hs, ser};

  psrm_partner u_partner (.want(want), .pclk(pclk), .pins(pins));
  psrm_top #(.STARTUP_NS(200)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .main_supply_ok(pins.vin_ok), .enable_undervoltage_input(pins.en),
    .driver_regulator_output_ok(pins.drv_ok), .external_driver_supply_ok(pins.ext_ok),
    .digital_supply_ok(pins.vdd_ok), .limp_home_input(pins.lh),
    .dimming_input(pins.dim), .bootstrap_ok(pins.boot_ok), .cal_valid(cal_valid),
    .cal_value(cal_value), .power_state(power_state), .internal_regulator_en(int_en),
    .driver_regulator_en(drv_en), .switching_en(sw), .high_side_gate_drivers_en(hs),
    .serial_en(ser), .register_reset(rr), .transmission_error_flag(txerr), .irq(irq));

  always #10 pclk = ~pclk;

  // Whole run needs well under 3000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      close_out;
    end
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask

  // Data is judged only on reads that should be answered
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic ee, input logic [31:0] ed);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk({31'h0, pslverr}, {31'h0, ee});
    if (!w && !ee) chk(prdata, ed);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic sett(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic pin(input psrm_pkg::psrm_pin_t v);
    @(posedge pclk);
    want <= v;
  endtask

  task automatic wait_st(input logic [1:0] s, output int c);
    c = 0;
    while (power_state !== s && c < 200) begin
      @(posedge pclk);
      c++;
    end
    chk({30'h0, power_state}, {30'h0, s});
  endtask

  task automatic note(input string s);
    $display("test %s done, %0d mismatches", s, n_fail);
  endtask

  task automatic t_reset;
    psrm_pkg::psrm_pin_t v;
    int                  c;
    v = GOOD;
    v.vin_ok = 1'b0;
    sett(1);
    chk({24'h0, txerr, rr, outs}, 32'hC0);
    pin(v);
    sett(30);
    chk({30'h0, power_state}, 32'h0);
    pin(GOOD);
    wait_st(psrm_pkg::PS_ACTIVE, c);
    chk({31'h0, c >= SU}, 32'h1);
    note("power_up");
  endtask

  task automatic t_active;
    psrm_pkg::psrm_pin_t v;
    v = GOOD;
    sett(2);
    chk({26'h0, outs}, 32'h3B);
    v.boot_ok = 2'b10;
    pin(v);
    sett(10);
    chk({26'h0, outs}, 32'h3D);
    v.dim = 1'b0;
    pin(v);
    sett(10);
    chk({31'h0, sw}, 32'h0);
    v = GOOD;
    v.en = 1'b0;
    pin(v);
    @(posedge pclk);
    pin(GOOD);
    sett(15);
    chk({26'h0, outs}, 32'h3B);
    note("active");
  endtask

  task automatic t_idle;
    int c;
    acc(1'b1, psrm_pkg::OFS_IRQ_CLR, 32'hF, 1'b0, 32'h0);
    acc(1'b1, psrm_pkg::OFS_IRQ_EN, 32'h1, 1'b0, 32'h0);
    acc(1'b1, psrm_pkg::OFS_MUX, 32'hA5, 1'b0, 32'h0);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, psrm_pkg::OFS_CTRL, 32'h1, 1'b0, 32'h0);
    wait_st(psrm_pkg::PS_IDLE, c);
    sett(2);
    chk({27'h0, irq, outs[5:2]}, 32'h1C);
    acc(1'b0, psrm_pkg::OFS_IRQ_ST, 32'h0, 1'b0, 32'h1);
    acc(1'b0, psrm_pkg::OFS_MUX, 32'h0, 1'b0, 32'hA5);
    acc(1'b0, psrm_pkg::OFS_STAT, 32'h0, 1'b0, 32'h7D35);
    acc(1'b0, 8'h1C, 32'h0, 1'b1, 32'h0);
    acc(1'b1, psrm_pkg::OFS_IRQ_EN, 32'h0, 1'b0, 32'h0);
    sett(1);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, psrm_pkg::OFS_IRQ_CLR, 32'h1, 1'b0, 32'h0);
    acc(1'b0, psrm_pkg::OFS_IRQ_ST, 32'h0, 1'b0, 32'h0);
    note("idle_irq");
  endtask

  task automatic t_soft;
    @(posedge pclk);
    cal_valid <= 1'b1;
    cal_value <= 8'h3C;
    @(posedge pclk);
    cal_valid <= 1'b0;
    acc(1'b1, psrm_pkg::OFS_CTRL, 32'hC, 1'b0, 32'h0);
    sett(2);
    chk({31'h0, txerr}, 32'h0);
    acc(1'b0, psrm_pkg::OFS_CAL, 32'h0, 1'b0, 32'h3C);
    acc(1'b1, psrm_pkg::OFS_CTRL, 32'h6, 1'b0, 32'h0);
    sett(2);
    chk({31'h0, txerr}, 32'h1);
    acc(1'b0, psrm_pkg::OFS_MUX, 32'h0, 1'b0, 32'hA5);
    acc(1'b0, psrm_pkg::OFS_CTRL, 32'h0, 1'b0, 32'h0);
    acc(1'b0, psrm_pkg::OFS_CAL, 32'h0, 1'b0, 32'h0);
    acc(1'b1, psrm_pkg::OFS_CTRL, 32'h4, 1'b0, 32'h0);
    acc(1'b0, psrm_pkg::OFS_CAL, 32'h0, 1'b0, 32'h3C);
    note("soft_reset");
  endtask

  task automatic t_supply;
    psrm_pkg::psrm_pin_t v;
    int                  c;
    v = GOOD;
    v.drv_ok = 1'b0;
    pin(v);
    sett(12);
    chk({28'h0, rr, sw, hs}, 32'h0);
    acc(1'b0, psrm_pkg::OFS_MUX, 32'h0, 1'b0, 32'hA5);
    v = GOOD;
    v.vdd_ok = 1'b0;
    pin(v);
    sett(12);
    chk({28'h0, rr, outs[2:0]}, 32'h8);
    acc(1'b0, psrm_pkg::OFS_MUX, 32'h0, 1'b1, 32'h0);
    pin(GOOD);
    wait_st(psrm_pkg::PS_ACTIVE, c);
    sett(12);
    acc(1'b0, psrm_pkg::OFS_MUX, 32'h0, 1'b0, 32'h0);
    note("supply_uv");
  endtask

  task automatic t_limp_en;
    psrm_pkg::psrm_pin_t v;
    int                  c;
    v = GOOD;
    v.lh = 1'b1;
    acc(1'b1, psrm_pkg::OFS_MUX, 32'h77, 1'b0, 32'h0);
    pin(v);
    wait_st(psrm_pkg::PS_LIMP, c);
    sett(3);
    acc(1'b0, psrm_pkg::OFS_MUX, 32'h0, 1'b0, 32'h0);
    acc(1'b1, psrm_pkg::OFS_MUX, 32'h5A, 1'b1, 32'h0);
    acc(1'b0, psrm_pkg::OFS_MUX, 32'h0, 1'b0, 32'h0);
    v = GOOD;
    v.en = 1'b0;
    pin(v);
    wait_st(psrm_pkg::PS_SLEEP, c);
    sett(3);
    chk({25'h0, rr, outs}, 32'h40);
    acc(1'b0, psrm_pkg::OFS_MUX, 32'h0, 1'b1, 32'h0);
    note("limp_enable");
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_active;
    t_idle;
    t_soft;
    t_supply;
    t_limp_en;
    close_out;
  end
endmodule // tb_power_state_reset_manager
`default_nettype wire
